// *** logic/csr_regs.sv ***
`timescale 1ns/1ps
module csr_regs
  import csr_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CE,
  input  wire logic        CS,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  ADAPTER_PRESENT,
  input  wire logic [3:0]  SIGNAL_LOSS,
  input  wire logic [3:0]  REFERENCE_LOSS,
  input  wire logic [3:0]  PHASE_ERROR,
  input  wire logic [3:0]  TRACK_ERROR,
  input  wire logic [3:0]  RAW_UP,
  input  wire logic [3:0]  EMULATION_ENABLE,
  input  wire logic [3:0]  COUNT_UP,
  input  wire logic [3:0]  COUNT_DOWN,
  input  wire logic [3:0]  PRELOAD_STROBE,
  output logic [31:0]      RDATA,
  output logic             RVALID,
  output logic [31:0]      PRELOAD_VALUE [4],
  output logic [31:0]      COUNT_VALUE [4]
);
  csr_snap_if sif ();

  logic [31:0] pre_q [CSR_NCH];
  logic [31:0] cnt_q [CSR_NCH];
  logic [3:0]  dir_q;
  logic        mc_en_q;
  logic [3:0]  mc_sel_q;
  logic [3:0]  pend_q;
  logic [3:0]  cap_d;
  logic        rd_pend_q;
  logic        rd_snap_q;
  logic [31:0] rd_word_q;
  logic [3:0]  pend_d;
  logic [31:0] rd_word_d;
  logic [1:0]  sts_ch;
  logic        hit_global;
  logic        hit_status;
  logic        hit_count;

  // multi-read sequencer, one-hot
  typedef enum logic [1:0] {
    CSR_SEQ_IDLE = 2'b01,
    CSR_SEQ_BUSY = 2'b10
  } csr_seq_t;
  csr_seq_t    seq_q;
  csr_seq_t    seq_d;

  // channel index of a word address within a bank of four
  function automatic logic [1:0] ch_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[3:2];
  endfunction

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'h10) && (a[1:0] == 2'b00);
  endfunction

  // any one fault cause flags the channel
  function automatic logic selftest_err(input logic [3:0] signal_loss, input logic [3:0] reference_loss,
                                        input logic [3:0] phs, input logic [3:0] trk,
                                        input logic [1:0] ch);
    return signal_loss[ch] | reference_loss[ch] | phs[ch] | trk[ch];
  endfunction

  // one region per access, first match wins
  always_comb begin
    hit_global = 1'b0;
    hit_status = 1'b0;
    hit_count  = 1'b0;
    if (ADDR == CSR_OFF_GLOBAL) begin
      hit_global = 1'b1;
    end else if (in_bank(ADDR, CSR_OFF_STATUS0)) begin
      hit_status = 1'b1;
    end else if (in_bank(ADDR, CSR_OFF_COUNT0)) begin
      hit_count = 1'b1;
    end
  end

  assign sts_ch = ch_of(ADDR, CSR_OFF_STATUS0);

  wire cnt_hit = CS && hit_count;
  wire [1:0] cnt_ch = ch_of(ADDR, CSR_OFF_COUNT0);

  // ==========================================================
  // preload holding registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        pre_q[i] <= CSR_RST_WORD;
      end
    end else if (CE && WR && cnt_hit) begin
      pre_q[cnt_ch] <= WDATA;
    end
  end

  // ==========================================================
  // encoder counters
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        cnt_q[i] <= CSR_RST_WORD;
      end
    end else if (CE) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        if (PRELOAD_STROBE[i]) begin
          cnt_q[i] <= pre_q[i];
        end else if (EMULATION_ENABLE[i] && (COUNT_UP[i] != COUNT_DOWN[i])) begin
          cnt_q[i] <= COUNT_UP[i] ? cnt_q[i] + 32'h1 : cnt_q[i] - 32'h1;
        end
      end
    end
  end

  // ==========================================================
  // direction of motion
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dir_q <= 4'h0;
    end else if (CE) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        if (EMULATION_ENABLE[i]) begin
          // counter steps give a trustworthy sense; static keeps last
          if (COUNT_UP[i] && !COUNT_DOWN[i]) begin
            dir_q[i] <= 1'b1;
          end else if (COUNT_DOWN[i] && !COUNT_UP[i]) begin
            dir_q[i] <= 1'b0;
          end
        end else begin
          dir_q[i] <= RAW_UP[i];
        end
      end
    end
  end

  // ==========================================================
  // global multi-read control
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mc_en_q  <= 1'b0;
      mc_sel_q <= 4'h0;
    end else if (CE && CS && WR && ADDR == CSR_OFF_GLOBAL) begin
      mc_en_q  <= WDATA[CSR_BIT_MC_EN];
      mc_sel_q <= WDATA[CSR_BIT_MC_SEL +: 4];
    end
  end

  // capture decision for this cycle
  always_comb begin
    cap_d = 4'h0;
    if (CS && RD && cnt_hit) begin
      if (mc_en_q && mc_sel_q[cnt_ch]) begin
        if (pend_q == 4'h0) begin
          cap_d = mc_sel_q;
        end else if (!pend_q[cnt_ch]) begin
          // reread inside a sequence fetches current data only
          cap_d[cnt_ch] = 1'b1;
        end
      end else begin
        cap_d[cnt_ch] = 1'b1;
      end
    end
  end

  // outstanding captures; opening read itself counts as read
  always_comb begin
    pend_d = pend_q;
    if (RD && cnt_hit && mc_en_q && mc_sel_q[cnt_ch]) begin
      if (pend_q == 4'h0) begin
        pend_d = mc_sel_q & ~(4'h1 << cnt_ch);
      end else begin
        pend_d[cnt_ch] = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_q <= 4'h0;
    end else if (CE) begin
      pend_q <= pend_d;
    end
  end

  // sequencer follows the outstanding set
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      CSR_SEQ_IDLE: begin
        if (pend_d != 4'h0) begin
          seq_d = CSR_SEQ_BUSY;
        end
      end
      CSR_SEQ_BUSY: begin
        if (pend_d == 4'h0) begin
          seq_d = CSR_SEQ_IDLE;
        end
      end
      default: begin
        seq_d = CSR_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_q <= CSR_SEQ_IDLE;
    end else if (CE) begin
      seq_q <= seq_d;
    end
  end

  assign sif.cap  = CE ? cap_d : 4'h0;
  assign sif.rsel = cnt_ch;
  always_comb begin
    for (int i = 0; i < CSR_NCH; i++) begin
      sif.cnt[i] = cnt_q[i];
    end
  end

  csr_snap_mem u_snap (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .ce    (CE),
    .sif   (sif)
  );

  // ==========================================================
  // read path: every word, snapshot or other, reaches RDATA two cycles after the read
  always_comb begin
    rd_word_d = CSR_RST_WORD;
    if (hit_global) begin
      rd_word_d[CSR_BIT_MC_EN]       = mc_en_q;
      rd_word_d[CSR_BIT_MC_SEL +: 4] = mc_sel_q;
      rd_word_d[CSR_BIT_MC_BUSY]     = (seq_q == CSR_SEQ_BUSY);
    end else if (hit_status) begin
      // fault causes are levels, taken as they stand at the read
      rd_word_d[CSR_BIT_ST_ERR] = selftest_err(SIGNAL_LOSS, REFERENCE_LOSS, PHASE_ERROR,
                                               TRACK_ERROR, sts_ch);
      rd_word_d[CSR_BIT_ST_ABS] = ~ADAPTER_PRESENT[sts_ch];
      rd_word_d[CSR_BIT_ST_DIR] = dir_q[sts_ch];
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_pend_q <= 1'b0;
    end else if (CE) begin
      rd_pend_q <= CS && RD;
    end
  end

  // only a counter read takes its word from the snapshot store
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_snap_q <= 1'b0;
    end else if (CE) begin
      rd_snap_q <= cnt_hit && RD;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_word_q <= CSR_RST_WORD;
    end else if (CE) begin
      rd_word_q <= rd_word_d;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RVALID <= 1'b0;
    end else if (CE) begin
      RVALID <= rd_pend_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= CSR_RST_WORD;
    end else if (CE) begin
      RDATA <= rd_snap_q ? sif.rdata : rd_word_q;
    end
  end

  // ==========================================================
  // observation copies, one cycle behind the registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        PRELOAD_VALUE[i] <= CSR_RST_WORD;
      end
    end else if (CE) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        PRELOAD_VALUE[i] <= pre_q[i];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        COUNT_VALUE[i] <= CSR_RST_WORD;
      end
    end else if (CE) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        COUNT_VALUE[i] <= cnt_q[i];
      end
    end
  end
endmodule

// *** logic/csr_pkg.sv ***
// How it works
// - status bit 1 reads one when no signal adapter is fitted.
// - status bit 0 carries converter self-test error, one means error, resets zero.
// - self-test error set on loss of signal or loss of reference.
// - self-test error set on phase error beyond 180 degrees.
// - self-test error set when output differs over 180 LSBs from angle.
// - direction bit is trustworthy only while encoder emulation is enabled.
// - without emulation direction mirrors raw up/down output of converter.
// - write to counter location stores 32-bit preload, counter untouched.
// - read of counter location returns snapshot, both registers reset zero.
// - preload register feeds every reference preload of the counter.
// - running count is captured into snapshot so reads are stable.
// - multi read captures all selected channels together on one read.
// - no new multi capture until every captured snapshot was read.
// - all registers reset by the bridge active-low local reset.
// - multi read channel select at bits 6-9 plus enable bit 5.
// - global status bit 10 reads one while multi read in progress.
// - direction bit 2, zero down, one up, keeps last when static.
// - encoder counter counts only while emulation enable bit 8 set.
package csr_pkg;
  localparam int CSR_NCH          = 4;
  localparam int CSR_AW           = 8;
  localparam logic [7:0] CSR_OFF_GLOBAL  = 8'h00;
  localparam logic [7:0] CSR_OFF_STATUS0 = 8'h2C;
  localparam logic [7:0] CSR_OFF_COUNT0  = 8'h3C;
  localparam int CSR_BIT_MC_EN    = 5;
  localparam int CSR_BIT_MC_SEL   = 6;
  localparam int CSR_BIT_MC_BUSY  = 10;
  localparam int CSR_BIT_ST_ERR   = 0;
  localparam int CSR_BIT_ST_ABS   = 1;
  localparam int CSR_BIT_ST_DIR   = 2;
  localparam logic [31:0] CSR_RST_WORD = 32'h0000_0000;
endpackage

// *** logic/csr_snap_if.sv ***
`timescale 1ns/1ps
interface csr_snap_if;
  logic [3:0]  cap;
  logic [31:0] cnt [4];
  logic [1:0]  rsel;
  logic [31:0] rdata;
  modport owner (output cap, output cnt, output rsel, input rdata);
  modport store (input cap, input cnt, input rsel, output rdata);
endinterface

// *** logic/csr_snap_mem.sv ***
`timescale 1ns/1ps
module csr_snap_mem
  import csr_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   ce,
  csr_snap_if.store   sif
);
  logic [31:0] mem_q [CSR_NCH];
  logic [31:0] rd_q;

  // snapshot store, register-read output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        mem_q[i] <= CSR_RST_WORD;
      end
    end else if (ce) begin
      for (int i = 0; i < CSR_NCH; i++) begin
        if (sif.cap[i]) begin
          mem_q[i] <= sif.cnt[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= CSR_RST_WORD;
    end else if (ce) begin
      // a capture in this cycle bypasses the store, else the read sees stale data
      if (sif.cap[sif.rsel]) begin
        rd_q <= sif.cnt[sif.rsel];
      end else begin
        rd_q <= mem_q[sif.rsel];
      end
    end
  end

  assign sif.rdata = rd_q;
endmodule

// *** dv/csr_regs_sva.sv ***
`timescale 1ns/1ps
// ======
// port checks, read latency of any read and channel 0
module csr_regs_sva (
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        CS,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic [3:0]  ADAPTER_PRESENT,
  input wire logic [3:0]  SIGNAL_LOSS,
  input wire logic [3:0]  REFERENCE_LOSS,
  input wire logic [3:0]  PHASE_ERROR,
  input wire logic [3:0]  TRACK_ERROR,
  input wire logic [3:0]  RAW_UP,
  input wire logic [3:0]  EMULATION_ENABLE,
  input wire logic [3:0]  COUNT_UP,
  input wire logic [3:0]  COUNT_DOWN,
  input wire logic [3:0]  PRELOAD_STROBE,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic [31:0] PRELOAD_VALUE [4],
  input wire logic [31:0] COUNT_VALUE [4]
);
  wire [3:0] bad = SIGNAL_LOSS | REFERENCE_LOSS | PHASE_ERROR | TRACK_ERROR;
  wire       st0 = CS && RD && ADDR == 8'h2C;
  wire       ee0 = EMULATION_ENABLE[0];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  AST_RD_LAT: assert property (CS && RD |-> ##2 RVALID)
    else $error("read not answered");
  AST_PRE_WR: assert property (CS && WR && ADDR == 8'h3C |-> ##2
    PRELOAD_VALUE[0] == $past(WDATA, 2)) else $error("preload not stored");
  AST_ERR: assert property (st0 |-> ##2 RDATA[0] == $past(bad[0], 2))
    else $error("self-test bit wrong");
  AST_ABS: assert property (st0 |-> ##2 RDATA[1] == !$past(ADAPTER_PRESENT[0], 2))
    else $error("adapter bit wrong");
  // direction register follows the raw pin one cycle late
  AST_RAW_DIR: assert property (st0 && !ee0 && !$past(ee0) |-> ##2 RDATA[2] ==
    $past(RAW_UP[0], 3)) else $error("raw direction wrong");
  AST_LOAD: assert property (PRELOAD_STROBE[0] |-> ##2
    COUNT_VALUE[0] == $past(PRELOAD_VALUE[0])) else $error("preload not loaded");
  AST_UP: assert property (ee0 && COUNT_UP[0] && !COUNT_DOWN[0] && !PRELOAD_STROBE[0]
    |-> ##2 COUNT_VALUE[0] == $past(COUNT_VALUE[0]) + 32'h1) else $error("no count up");
  AST_HOLD: assert property (!ee0 && !PRELOAD_STROBE[0]
    |-> ##2 $stable(COUNT_VALUE[0])) else $error("count moved while off");
endmodule
bind csr_regs csr_regs_sva u_csr_regs_sva (.*);

// *** dv/csr_bridge_model.sv ***
`timescale 1ns/1ps
// ======
// local bus side of the bridge
module csr_bridge_model (
  input  wire logic        clk,
  input  wire logic        bus_rst_n,
  input  wire logic        sw_rst,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  output logic             local_rst_n,
  output logic             cs,
  output logic             wr,
  output logic             rd,
  output logic [7:0]       addr,
  output logic [31:0]      wdata
);
  // held low for as long as software keeps the bit set
  assign local_rst_n = bus_rst_n & ~sw_rst;
  // host software steps resolution down once per error seen
  int res_drops = 0;
  initial begin
    {cs, wr, rd, addr, wdata} = '0;
  end
  // word accesses only; idle bus shows inverted last value
  task wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) #1 {cs, wr, addr, wdata} = {2'b11, a, d};
    @(posedge clk) #1 {cs, wr, addr, wdata} = {2'b00, ~a, ~d};
  endtask
  task rd32(input logic [7:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk) #1 {cs, rd, addr} = {2'b11, a};
    @(posedge clk) #1 {cs, rd, addr} = {2'b00, ~a};
    ok = 0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      ok = rvalid === 1'b1;
      d = rdata;
    end
    if (ok && a >= 8'h2C && a <= 8'h38 && d[0]) begin
      res_drops++;
    end
    #1;
  endtask
endmodule

// *** dv/tb_csr_regs.sv ***
`timescale 1ns/1ps
// ======
// register bank bench
module tb_csr_regs;
  logic clk = 0, brst_n = 0, sw = 0, rst_n, cs, wr, rd, rv, ok;
  logic [7:0] ad;
  logic [31:0] wd, rdat, d, pv [4], cv [4];
  logic [3:0] ap = 4'h5, ru = 0, ee = 0, cu = 0, cd = 0, ps = 0;
  logic [15:0] cz = 0;
  int err_total = 0, n_compared = 0;
  initial forever #2 clk = ~clk;
  csr_bridge_model u_csr_bridge_model (.clk(clk), .bus_rst_n(brst_n), .sw_rst(sw),
    .rdata(rdat), .rvalid(rv), .local_rst_n(rst_n), .cs(cs), .wr(wr), .rd(rd),
    .addr(ad), .wdata(wd));
  csr_regs u_csr_regs (.REF_CLK(clk), .RESET_N(rst_n), .CE(1'b1), .CS(cs), .WR(wr),
    .RD(rd), .ADDR(ad), .WDATA(wd), .ADAPTER_PRESENT(ap), .SIGNAL_LOSS(cz[3:0]),
    .REFERENCE_LOSS(cz[7:4]), .PHASE_ERROR(cz[11:8]), .TRACK_ERROR(cz[15:12]),
    .RAW_UP(ru), .EMULATION_ENABLE(ee), .COUNT_UP(cu), .COUNT_DOWN(cd),
    .PRELOAD_STROBE(ps), .RDATA(rdat), .RVALID(rv), .PRELOAD_VALUE(pv), .COUNT_VALUE(cv));
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    u_csr_bridge_model.rd32(a, d, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] rvalid for read %h exp 1 got %b", a, ok);
    end
    chk($sformatf("read %h", a), e, d);
  endtask
  task cnt(input logic [3:0] u, input logic [3:0] dn, input logic [3:0] p);
    @(posedge clk) #1 {cu, cd, ps} = {u, dn, p};
    @(posedge clk) #1 {cu, cd, ps} = '0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 brst_n = 1;
    for (int c = 0; c < 4; c++) rchk(8'h3C + 8'(4 * c), 0);
    u_csr_bridge_model.wr32(8'h3C, 32'hA5A5_0F0F);
    rchk(8'h3C, 0);
    chk("preload", 32'hA5A5_0F0F, pv[0]);
    cnt(0, 0, 1);
    rchk(8'h3C, 32'hA5A5_0F0F);
    ee = 1;
    cnt(1, 0, 0);
    cnt(1, 0, 0);
    rchk(8'h3C, 32'hA5A5_0F11);
    rchk(8'h2C, 32'h4);
    cnt(0, 1, 0);
    rchk(8'h3C, 32'hA5A5_0F10);
    rchk(8'h2C, 32'h0);
    {ee, ru} = 8'h01;
    cnt(1, 0, 0);
    rchk(8'h3C, 32'hA5A5_0F10);
    rchk(8'h2C, 32'h4);
    ru = 0;
    for (int k = 0; k < 5; k++) begin
      cz = 16'h1 << (k * 5);
      rchk(8'h2C + 8'(4 * (k % 4)), {30'h0, ~ap[k % 4], k < 4});
    end
    cz = 0;
    chk("resolution drops", 4, u_csr_bridge_model.res_drops);
    u_csr_bridge_model.wr32(8'h00, 32'hE0);
    rchk(8'h00, 32'hE0);
    rchk(8'h3C, 32'hA5A5_0F10);
    rchk(8'h00, 32'h4E0);
    u_csr_bridge_model.wr32(8'h40, 32'h1234_5678);
    cnt(0, 0, 2);
    rchk(8'h40, 0);
    rchk(8'h00, 32'hE0);
    rchk(8'h40, 32'h1234_5678);
    rchk(8'h3C, 32'hA5A5_0F10);
    rchk(8'h80, 0);
    sw = 1;
    repeat (3) @(posedge clk);
    #1 chk("local reset", 0, {31'h0, rst_n});
    sw = 0;
    rchk(8'h00, 0);
    chk("count", 0, cv[0]);
    give_verdict;
  end
endmodule
